// File: verilog/clk_input_status.sv
// second-input divider, rate selects and live alarm/lock status registers
// Behaviour
// RULE1: second-input divider is 19 bits spread high[2:0], mid[7:0], low[7:0].
// RULE2: 3-bit rate codes 0..5 pick monitor range; codes 6 and 7 reserved.
// RULE3: active bit 0 is 1 while first input drives the PLL.
// RULE4: active bit 1 is 1 while second input drives the PLL.
// RULE5: absent register bit 2 second input, bit 1 first input, live.
// RULE6: absent register bit 0 is the reference input alarm, live.
// RULE7: bit 6 reads 1 only once hold history is filled.
// RULE8: offset alarms on bit 2 second input, bit 1 first input.
// RULE9: bit 0 reads 1 while the PLL is unlocked, 0 locked.
// RULE10: each live alarm feeds an outside sticky flag cleared by writing 0.
// RULE11: writes to read-only and reserved bits ignored; reserved reads zero; the active register reads 0x20 until its first capture after reset.
// RULE12: status bytes are captured together so one read is coherent.
`timescale 1ns/1ps
`default_nettype none
module clk_input_status
	import clk_status_pkg::*;
(
	input wire logic clk_sys, // system clock
	input wire logic rst_n, // async reset, active low
	input wire logic reg_wr, // host write strobe
	input wire logic reg_rd, // host read strobe
	input wire logic [clk_status_pkg::ADDR_W-1:0] reg_addr, // register offset
	input wire logic [clk_status_pkg::DATA_W-1:0] reg_wdata, // write data
	output logic [clk_status_pkg::DATA_W-1:0] reg_rdata, // read data, registered
	output logic reg_hit, // address maps to this bank
	input wire clk_status_pkg::input_sel_t input_select, // input chosen by selection logic
	input wire logic first_input_signal_absent, // live alarm, first input
	input wire logic second_input_signal_absent, // live alarm, second input
	input wire logic reference_signal_absent, // live alarm, reference
	input wire logic first_input_freq_offset, // live offset alarm, first input
	input wire logic second_input_freq_offset, // live offset alarm, second input
	input wire logic pll_unlocked, // live lock state, 1 unlocked
	input wire logic hold_history_valid, // hold history filled
	output logic [clk_status_pkg::DIV_W-1:0] second_input_divider, // divider value
	output logic [clk_status_pkg::RATE_W-1:0] first_input_rate_select, // monitor range
	output logic [clk_status_pkg::RATE_W-1:0] second_input_rate_select, // monitor range
	output logic first_input_active, // first input drives the PLL
	output logic second_input_active, // second input drives the PLL
	output logic [4:0] live_alarms, // to sticky flags: ref, abs1, abs2, fos1, fos2... see note
	output logic rate_write_refused // pulse: reserved rate code written
);
	import clk_status_pkg::*;

	typedef struct packed {
		logic [DIV_W-1:0] div;
		logic [RATE_W-1:0] rate1;
		logic [RATE_W-1:0] rate2;
		logic [DATA_W-1:0] rdata;
		logic refused;
	} bank_state_t;

	bank_state_t s_q;
	bank_state_t s_d;

	logic [7:0] live_active;
	logic [7:0] live_absent;
	logic [7:0] live_hold;
	logic [7:0] snap_active;
	logic [7:0] snap_absent;
	logic [7:0] snap_hold;
	logic [2:0] rate1_next;
	logic [2:0] rate2_next;
	logic rate1_bad;
	logic rate2_bad;
	logic act1;
	logic act2;
	logic [DIV_W-1:0] div_next;
	logic [7:0] rd_byte;
	// one-hot decode, shared by the write and read paths
	logic wr_div_high;
	logic wr_div_mid;
	logic wr_div_low;
	logic wr_rate;
	logic rd_div_high;
	logic rd_div_mid;
	logic rd_div_low;
	logic rd_rate;
	logic rd_active;
	logic rd_absent;
	logic rd_hold;
	logic rd_unmapped;

	function automatic logic [7:0] place_bit(input logic v, input int pos);
		logic [7:0] r;
		r = RST_ZERO;
		r[pos[2:0]] = v;
		return r;
	endfunction

	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		logic hit;
		hit = 1'b0;
		unique case (a)
			OFF_DIV_HIGH, OFF_DIV_MID, OFF_DIV_LOW, OFF_RATE_SEL: begin
				hit = 1'b1;
			end
			OFF_ACTIVE, OFF_ABSENT, OFF_HOLD_LOCK: begin
				hit = 1'b1;
			end
			default: begin
				hit = 1'b0;
			end
		endcase
		return hit;
	endfunction

	// status bytes: any bit not placed here is reserved and reads zero, except active bit 5 until the first capture after reset
	function automatic logic [7:0] pack_active(input logic a1, input logic a2);
		return place_bit(a1, ACT1_BIT) | place_bit(a2, ACT2_BIT);
	endfunction

	function automatic logic [7:0] pack_absent(input logic ref_abs, input logic abs1, input logic abs2);
		logic [7:0] r;
		r = place_bit(ref_abs, ABS_REF_BIT);
		r = r | place_bit(abs1, ABS1_BIT);
		r = r | place_bit(abs2, ABS2_BIT);
		return r;
	endfunction

	function automatic logic [7:0] pack_hold(input logic u, input logic f1, input logic f2, input logic hv);
		logic [7:0] r;
		r = place_bit(u, UNLOCK_BIT);
		r = r | place_bit(f1, FOS1_BIT);
		r = r | place_bit(f2, FOS2_BIT);
		r = r | place_bit(hv, HOLD_VALID_BIT);
		return r;
	endfunction

	function automatic logic [7:0] high_byte(input logic [DIV_W-1:0] d);
		logic [7:0] r;
		r = RST_ZERO;
		r[HIGH_FIELD_W-1:0] = d[DIV_HIGH_LSB +: HIGH_FIELD_W];
		return r;
	endfunction

	function automatic logic [7:0] rate_byte(input logic [RATE_W-1:0] r1, input logic [RATE_W-1:0] r2);
		logic [7:0] r;
		r = RST_ZERO;
		r[RATE1_LSB +: RATE_W] = r1;
		r[RATE2_LSB +: RATE_W] = r2;
		return r;
	endfunction

	// an input counts as active only while selected and its signal-absent alarm is clear
	assign act1 = (input_select == SEL_FIRST) && !first_input_signal_absent; // RULE3
	assign act2 = (input_select == SEL_SECOND) && !second_input_signal_absent; // RULE4

	always_comb begin
		live_active = pack_active(act1, act2); // RULE3 RULE4
		live_absent = pack_absent(reference_signal_absent, // RULE6
			first_input_signal_absent, // RULE5
			second_input_signal_absent); // RULE5
		live_hold = pack_hold(pll_unlocked, // RULE9
			first_input_freq_offset, // RULE8
			second_input_freq_offset, // RULE8
			hold_history_valid); // RULE7
	end

	// snapshot refreshes every cycle except the one a read is served from
	status_snapshot u_snap (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.capture(!reg_rd), // RULE12
		.live_active(live_active),
		.live_absent(live_absent),
		.live_hold(live_hold),
		.snap_active(snap_active),
		.snap_absent(snap_absent),
		.snap_hold(snap_hold)
	);

	rate_guard u_guard1 (
		.cur_rate(s_q.rate1),
		.new_rate(reg_wdata[RATE1_LSB +: RATE_W]),
		.next_rate(rate1_next),
		.refused(rate1_bad)
	);

	rate_guard u_guard2 (
		.cur_rate(s_q.rate2),
		.new_rate(reg_wdata[RATE2_LSB +: RATE_W]),
		.next_rate(rate2_next),
		.refused(rate2_bad)
	);

	// decode once so the write and read paths cannot disagree on an offset
	always_comb begin
		wr_div_high = 1'b0;
		wr_div_mid = 1'b0;
		wr_div_low = 1'b0;
		wr_rate = 1'b0;
		rd_div_high = 1'b0;
		rd_div_mid = 1'b0;
		rd_div_low = 1'b0;
		rd_rate = 1'b0;
		rd_active = 1'b0;
		rd_absent = 1'b0;
		rd_hold = 1'b0;
		rd_unmapped = 1'b0;
		unique case (reg_addr)
			OFF_DIV_HIGH: begin
				wr_div_high = reg_wr;
				rd_div_high = reg_rd;
			end
			OFF_DIV_MID: begin
				wr_div_mid = reg_wr;
				rd_div_mid = reg_rd;
			end
			OFF_DIV_LOW: begin
				wr_div_low = reg_wr;
				rd_div_low = reg_rd;
			end
			OFF_RATE_SEL: begin
				wr_rate = reg_wr;
				rd_rate = reg_rd;
			end
			// status offsets take no write strobe, so host writes fall away
			OFF_ACTIVE: begin
				rd_active = reg_rd; // RULE11
			end
			OFF_ABSENT: begin
				rd_absent = reg_rd; // RULE11
			end
			OFF_HOLD_LOCK: begin
				rd_hold = reg_rd; // RULE11
			end
			default: begin
				rd_unmapped = reg_rd; // RULE11
			end
		endcase
	end

	assign reg_hit = is_mapped(reg_addr);

	// divider bytes land independently; the host sees each one at once
	always_comb begin
		div_next = s_q.div;
		if (wr_div_high) begin
			div_next[DIV_HIGH_LSB +: HIGH_FIELD_W] = reg_wdata[HIGH_FIELD_W-1:0]; // RULE1 RULE11
		end
		if (wr_div_mid) begin
			div_next[DIV_MID_LSB +: DATA_W] = reg_wdata; // RULE1
		end
		if (wr_div_low) begin
			div_next[DATA_W-1:0] = reg_wdata; // RULE1
		end
	end

	// unmapped offsets and reserved bits come out as zero, bar active bit 5 until the first snapshot capture
	always_comb begin
		rd_byte = RST_ZERO;
		if (rd_div_high) begin
			rd_byte = high_byte(s_q.div); // RULE1 RULE11
		end
		if (rd_div_mid) begin
			rd_byte = s_q.div[DIV_MID_LSB +: DATA_W]; // RULE1
		end
		if (rd_div_low) begin
			rd_byte = s_q.div[DATA_W-1:0]; // RULE1
		end
		if (rd_rate) begin
			rd_byte = rate_byte(s_q.rate1, s_q.rate2); // RULE2 RULE11
		end
		if (rd_active) begin
			rd_byte = snap_active; // RULE3 RULE4 RULE12
		end
		if (rd_absent) begin
			rd_byte = snap_absent; // RULE5 RULE6 RULE12
		end
		if (rd_hold) begin
			rd_byte = snap_hold; // RULE7 RULE8 RULE9 RULE12
		end
		if (rd_unmapped) begin
			rd_byte = RST_ZERO; // RULE11
		end
	end

	always_comb begin
		s_d = s_q;
		s_d.div = div_next;
		s_d.refused = 1'b0;
		// a reserved code in one field leaves the other field free to change
		if (wr_rate) begin
			s_d.rate1 = rate1_next; // RULE2
			s_d.rate2 = rate2_next; // RULE2
			s_d.refused = rate1_bad | rate2_bad; // RULE2
		end
		// read data moves only on a read, so a slow host sees a steady byte
		if (reg_rd) begin
			s_d.rdata = rd_byte; // RULE12
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '{div: RST_DIVIDER, rate1: RST_RATE, rate2: RST_RATE, rdata: RST_ZERO, refused: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata = s_q.rdata;
	assign second_input_divider = s_q.div;
	assign first_input_rate_select = s_q.rate1;
	assign second_input_rate_select = s_q.rate2;
	assign first_input_active = act1;
	assign second_input_active = act2;
	assign rate_write_refused = s_q.refused;
	// sticky flags live outside; they take these live levels
	assign live_alarms = {second_input_freq_offset, first_input_freq_offset,
		second_input_signal_absent, first_input_signal_absent, reference_signal_absent}; // RULE10
endmodule
`default_nettype wire

// File: verilog/clk_status_pkg.sv
// constants, register map and field layout of the input divider and alarm status bank
package clk_status_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int DIV_W = 19;
	localparam int RATE_W = 3;

	localparam logic [7:0] OFF_DIV_HIGH = 8'h2E;
	localparam logic [7:0] OFF_DIV_MID = 8'h2F;
	localparam logic [7:0] OFF_DIV_LOW = 8'h30;
	localparam logic [7:0] OFF_RATE_SEL = 8'h37;
	localparam logic [7:0] OFF_ACTIVE = 8'h80;
	localparam logic [7:0] OFF_ABSENT = 8'h81;
	localparam logic [7:0] OFF_HOLD_LOCK = 8'h82;

	localparam logic [18:0] RST_DIVIDER = 19'h00000;
	localparam logic [2:0] RST_RATE = 3'h0;
	localparam logic [2:0] RATE_MAX_LEGAL = 3'h5;

	localparam int DIV_HIGH_LSB = 16;
	localparam int DIV_MID_LSB = 8;
	localparam int HIGH_FIELD_W = 3;
	localparam int RATE2_LSB = 3;
	localparam int RATE1_LSB = 0;

	localparam int ACT1_BIT = 0;
	localparam int ACT2_BIT = 1;
	localparam int ABS_REF_BIT = 0;
	localparam int ABS1_BIT = 1;
	localparam int ABS2_BIT = 2;
	localparam int UNLOCK_BIT = 0;
	localparam int FOS1_BIT = 1;
	localparam int FOS2_BIT = 2;
	localparam int HOLD_VALID_BIT = 6;

	localparam logic [7:0] RST_ACTIVE_REG = 8'h20;
	localparam logic [7:0] RST_ZERO = 8'h00;

	typedef enum logic [1:0] {
		SEL_NONE = 2'b00,
		SEL_FIRST = 2'b01,
		SEL_SECOND = 2'b10
	} input_sel_t;
endpackage

// File: verilog/status_snapshot.sv
// coherent snapshot of live alarm, lock and active-input bits
`timescale 1ns/1ps
`default_nettype none
module status_snapshot
	import clk_status_pkg::*;
(
	input wire logic clk_sys, // system clock
	input wire logic rst_n, // async reset, active low
	input wire logic capture, // load new snapshot
	input wire logic [7:0] live_active, // live active-input byte
	input wire logic [7:0] live_absent, // live signal-absent byte
	input wire logic [7:0] live_hold, // live hold/offset/lock byte
	output logic [7:0] snap_active, // held active-input byte
	output logic [7:0] snap_absent, // held signal-absent byte
	output logic [7:0] snap_hold // held hold/offset/lock byte
);
	typedef struct packed {
		logic [7:0] act;
		logic [7:0] abs;
		logic [7:0] hold;
	} snap_state_t;

	snap_state_t s_q;
	snap_state_t s_d;

	// all three bytes load on one edge so a read never mixes two moments
	always_comb begin
		s_d = s_q;
		if (capture) begin
			s_d.act = live_active; // RULE12
			s_d.abs = live_absent; // RULE12
			s_d.hold = live_hold; // RULE12
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '{act: RST_ACTIVE_REG, abs: RST_ZERO, hold: RST_ZERO};
		end else begin
			s_q <= s_d;
		end
	end

	assign snap_active = s_q.act;
	assign snap_absent = s_q.abs;
	assign snap_hold = s_q.hold;
endmodule
`default_nettype wire

// File: verilog/rate_guard.sv
// keeps a rate-select field from taking a reserved code
`timescale 1ns/1ps
`default_nettype none
module rate_guard
	import clk_status_pkg::*;
(
	input wire logic [2:0] cur_rate, // stored rate code
	input wire logic [2:0] new_rate, // code from the host write
	output logic [2:0] next_rate, // code to store
	output logic refused // host tried a reserved code
);
	// a reserved code would leave the offset monitor with no range
	always_comb begin
		refused = (new_rate > RATE_MAX_LEGAL); // RULE2
		next_rate = refused ? cur_rate : new_rate; // RULE2
	end
endmodule
`default_nettype wire

// File: dv/clk_input_status_chk.sv
// concurrent checks on the divider and status bank ports
`timescale 1ns/1ps
`default_nettype none
module clk_input_status_chk
	import clk_status_pkg::*;
(
	input wire logic clk_sys, // clock
	input wire logic rst_n, // reset
	input wire logic reg_wr, // write
	input wire logic reg_rd, // read
	input wire logic [7:0] reg_addr, // offset
	input wire logic [7:0] reg_wdata, // data in
	input wire logic [7:0] reg_rdata, // data out
	input wire logic reg_hit, // mapped
	input wire clk_status_pkg::input_sel_t input_select, // choice
	input wire logic first_input_signal_absent, // alarm
	input wire logic second_input_signal_absent, // alarm
	input wire logic reference_signal_absent, // alarm
	input wire logic first_input_freq_offset, // offset alarm
	input wire logic second_input_freq_offset, // offset alarm
	input wire logic [18:0] second_input_divider, // divider
	input wire logic [2:0] first_input_rate_select, // range
	input wire logic [2:0] second_input_rate_select, // range
	input wire logic first_input_active, // active
	input wire logic second_input_active, // active
	input wire logic [4:0] live_alarms, // to sticky flags
	input wire logic rate_write_refused // pulse
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	act_first_a: assert property (first_input_active == (input_select == SEL_FIRST && !first_input_signal_absent))
		else $error("first input active flag wrong");
	act_second_a: assert property (second_input_active == (input_select == SEL_SECOND && !second_input_signal_absent))
		else $error("second input active flag wrong");
	div_high_a: assert property (reg_wr && reg_addr == OFF_DIV_HIGH |=> {5'h00, second_input_divider[18:16]} == ($past(reg_wdata) & 8'h07))
		else $error("divider top bits not written");
	div_mid_a: assert property (reg_wr && reg_addr == OFF_DIV_MID |=> second_input_divider[15:8] == $past(reg_wdata))
		else $error("divider middle byte not written");
	div_low_a: assert property (reg_wr && reg_addr == OFF_DIV_LOW |=> second_input_divider[7:0] == $past(reg_wdata))
		else $error("divider low byte not written");
	rate_keep_a: assert property (reg_wr && reg_addr == OFF_RATE_SEL && reg_wdata[5:3] > RATE_MAX_LEGAL |=> rate_write_refused && $stable(second_input_rate_select))
		else $error("reserved rate code not refused");
	rate_take_a: assert property (reg_wr && reg_addr == OFF_RATE_SEL && reg_wdata[2:0] <= RATE_MAX_LEGAL |=> {5'h00, first_input_rate_select} == ($past(reg_wdata) & 8'h07))
		else $error("legal rate code not stored");
	unmapped_rd_a: assert property (reg_rd && !reg_hit |=> reg_rdata == RST_ZERO)
		else $error("unmapped read not zero");
	rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without a read");
	rate1_keep_a: assert property (reg_wr && reg_addr == OFF_RATE_SEL && reg_wdata[2:0] > RATE_MAX_LEGAL
		|=> rate_write_refused && $stable(first_input_rate_select))
		else $error("reserved first rate code not refused");
	refused_clear_a: assert property (reg_wr && reg_addr == OFF_RATE_SEL && reg_wdata[5:3] <= RATE_MAX_LEGAL
		&& reg_wdata[2:0] <= RATE_MAX_LEGAL |=> !rate_write_refused)
		else $error("legal rate write flagged as refused");
	alarm_vec_a: assert property (live_alarms == {second_input_freq_offset, first_input_freq_offset,
		second_input_signal_absent, first_input_signal_absent, reference_signal_absent})
		else $error("live alarm vector wrong");
endmodule
`default_nettype wire

// File: dv/host_model.sv
// host register master: one-cycle strobes launched at the falling edge
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input wire logic clk_sys, // clock
	output logic reg_wr, // write strobe
	output logic reg_rd, // read strobe
	output logic [7:0] reg_addr, // offset
	output logic [7:0] reg_wdata // data
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		reg_wr = wr;
		reg_rd = !wr;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk_sys);
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		// released data flips so a stale byte is never mistaken for a live one
		reg_wdata = ~d;
	endtask
endmodule
`default_nettype wire

// File: dv/testbench.sv
// random live alarms and host traffic checked against a bench register model
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import clk_status_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic reg_wr, reg_rd, abs1, abs2, absr, fos1, fos2, unl, hold;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	input_sel_t sel = SEL_NONE;
	logic [18:0] m_div = 19'h00000;
	logic [2:0] m_r1 = 3'h0;
	logic [2:0] m_r2 = 3'h0;
	logic [7:0] expq[$];
	logic [31:0] w;
	int fails = 0;
	int checks_done = 0;
	int seed = 32'h6d35;
	always #10 clk_sys = ~clk_sys;
	host_model host (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
	clk_input_status dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(), .input_select(sel),
		.first_input_signal_absent(abs1), .second_input_signal_absent(abs2), .reference_signal_absent(absr),
		.first_input_freq_offset(fos1), .second_input_freq_offset(fos2), .pll_unlocked(unl),
		.hold_history_valid(hold), .second_input_divider(), .first_input_rate_select(),
		.second_input_rate_select(), .first_input_active(), .second_input_active(), .live_alarms(),
		.rate_write_refused());
	task automatic stop_test();
		$display("checks_done %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		expq.push_back(e);
		host.access(1'b0, a, 8'h00);
	endtask
	// read data lands on the rising edge that samples the read; it is checked at the next falling edge
	always @(posedge clk_sys) begin
		if (rst_n === 1'b1 && reg_rd === 1'b1) begin
			@(negedge clk_sys);
			checks_done++;
			if (reg_rdata !== expq[0]) begin
				fails++;
				$display("unexpected reg_rdata expected %h seen %h", expq[0], reg_rdata);
			end
			void'(expq.pop_front());
		end
	end
	initial begin
		{abs1, abs2, absr, fos1, fos2, unl, hold} = 7'h00;
		repeat (8) @(negedge clk_sys);
		rst_n = 1'b1;
		rd(OFF_DIV_MID, RST_ZERO);
		for (int i = 0; i < 40; i++) begin
			w = $random(seed);
			{abs1, abs2, absr, fos1, fos2, unl, hold} = w[6:0];
			sel = w[8] ? SEL_SECOND : (w[7] ? SEL_FIRST : SEL_NONE);
			w = $random(seed);
			host.access(1'b1, OFF_DIV_HIGH, w[7:0]);
			host.access(1'b1, OFF_DIV_MID, w[15:8]);
			host.access(1'b1, OFF_DIV_LOW, w[23:16]);
			m_div = {w[2:0], w[15:8], w[23:16]};
			// random rate codes include the reserved 6 and 7 on purpose
			host.access(1'b1, OFF_RATE_SEL, w[31:24]);
			if (w[29:27] <= RATE_MAX_LEGAL) m_r2 = w[29:27];
			if (w[26:24] <= RATE_MAX_LEGAL) m_r1 = w[26:24];
			host.access(1'b1, OFF_ACTIVE + w[1:0], w[23:16]);
			rd(OFF_DIV_HIGH, {5'h00, m_div[18:16]});
			rd(OFF_DIV_MID, m_div[15:8]);
			rd(OFF_DIV_LOW, m_div[7:0]);
			rd(OFF_RATE_SEL, {2'b00, m_r2, m_r1});
			rd(OFF_ACTIVE, {6'h00, sel == SEL_SECOND && !abs2, sel == SEL_FIRST && !abs1});
			rd(OFF_ABSENT, {5'h00, abs2, abs1, absr});
			rd(OFF_HOLD_LOCK, {1'b0, hold, 3'h0, fos2, fos1, unl});
			rd(8'h83, RST_ZERO);
			if (i == 20) begin
				rst_n = 1'b0;
				@(negedge clk_sys);
				rst_n = 1'b1;
				m_div = RST_DIVIDER;
				m_r1 = RST_RATE;
				m_r2 = RST_RATE;
				rd(OFF_RATE_SEL, RST_ZERO);
			end
		end
		repeat (2) @(negedge clk_sys);
		// a read whose data never arrived leaves a note behind
		if (expq.size() != 0) begin
			fails++;
			$display("unexpected pending_reads expected 0 seen %0d", expq.size());
		end
		stop_test();
	end
endmodule
bind clk_input_status clk_input_status_chk chk (.*);
`default_nettype wire
